// *** verilog/sih_pkg.sv ***
package sih_pkg;

  // handshake state codes, st3..st0
  typedef enum logic [3:0] {
    SIH_IDLE  = 4'h0,
    SIH_WR1   = 4'h9,
    SIH_WR2   = 4'h1,
    SIH_WR3   = 4'h3,
    SIH_ACKS  = 4'h7,
    SIH_WR5   = 4'h6,
    SIH_WR6   = 4'h2,
    SIH_HOLD  = 4'hA,
    SIH_LOOP1 = 4'hE,
    SIH_LOOP2 = 4'hC,
    SIH_LOOP3 = 4'h8,
    SIH_CLR0  = 4'h4
  } sih_state_t;

  // port select, {a2, a1}
  localparam logic [1:0] SIH_SEL_PORT_A = 2'h0;
  localparam logic [1:0] SIH_SEL_PORT_B = 2'h1;
  localparam logic [1:0] SIH_SEL_CTRL = 2'h3;

  // control word byte address and the bit that makes port A an input
  localparam logic [7:0] SIH_CTRL_ADDR = 8'hCE;
  localparam int SIH_CTRL_PA_IN_BIT = 4;

  // write-to-ack latency
  localparam int SIH_CLK_NS = 10;
  localparam int SIH_ACK_DELAY_CLK = 7;
  localparam int SIH_ACK_DELAY_NS = SIH_ACK_DELAY_CLK * SIH_CLK_NS;

endpackage

// *** verilog/sih_parity.sv ***
`timescale 1ns/1ps
// odd parity generation and receive check
module sih_parity (
  input wire logic [7:0] bus_data_i,
  input wire logic bus_parity_i,
  output logic parity_gen_o,
  output logic parity_bad_o
);

  logic partial_parity_a;
  logic partial_parity_b;
  logic partial_parity_c;

  always_comb begin
    partial_parity_a = ^bus_data_i[2:0];
    partial_parity_b = ^bus_data_i[5:3];
    partial_parity_c = ^bus_data_i[7:6];
    // odd: total of ones over data and parity is odd
    parity_gen_o = ~(partial_parity_a ^ partial_parity_b ^ partial_parity_c);
    parity_bad_o = ~(partial_parity_a ^ partial_parity_b ^ partial_parity_c
                     ^ bus_parity_i);
  end

endmodule

// *** verilog/sih_handshake.sv ***
`timescale 1ns/1ps
// What this block does
// - interface-enable bit high forces the state machine into idle 0000
// - state machine stays idle during selection; host waits for busy
// - data/command and direction lines encode the transfer phase
// - req while ack negated, then ack, then req drops, then ack drops
// - data byte valid before ack and held until ack released
// - ack-drive enable set in 0111, drops with req or disable; held into idle for ack
// - transceiver enabled on port-A-input flag or output phase while enabled
// - control write with data bit four high sets port-A-input flag
// - transceiver direction is a buffered copy of the direction line
// - output bytes: three states, 0111 sets enable, two states, then idle
// - seven clocks from port A write to ack assertion
// - dma request on idle, no enable, enabled, req and data phase, with no port A write
// - interrupt on req with command phase, or any req in state 1010
// - output path starts on port A write in late T3 with req, output
// - port B write from idle with bit four low enters holding path
// - input parity mismatch sets latch until cleared on way to idle
// - both parity outputs drive only when enabled, output, buffer on
// - generated parity is odd and never disturbs the error latch
// - port B write with bit four high from idle clears the latch
// - holding state 1010 kept until port B read, then loops to idle
module sih_handshake (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic port_chip_select_n_i,
  input wire logic io_write_n_i,
  input wire logic io_read_n_i,
  input wire logic [1:0] port_addr_i,
  input wire logic t3_second_half_i,
  input wire logic data_bit_four_i,
  input wire logic interface_enable_bit_i,
  input wire logic bus_req_n_i,
  input wire logic bus_dc_i,
  input wire logic bus_oi_i,
  input wire logic [7:0] bus_data_i,
  input wire logic bus_parity_i,
  output logic bus_ack_n_o,
  output logic dma_request_out_o,
  output logic bus_interrupt_out_o,
  output logic transceiver_enable_n_o,
  output logic transceiver_direction_o,
  output logic parity_out_a_o,
  output logic parity_out_a_oe_o,
  output logic parity_out_b_o,
  output logic parity_out_b_oe_o,
  output logic parity_error_latch_o,
  output logic port_a_input_flag_o,
  output logic [3:0] state_o
);

  sih_pkg::sih_state_t state_q;
  sih_pkg::sih_state_t state_d;
  logic ack_drive_enable_q;
  logic port_a_input_flag_q;
  logic parity_error_latch_q;
  logic en;
  logic req;
  logic idle;
  logic cs;
  logic late_wr;
  logic late_rd;
  logic pa_write;
  logic pa_any_write;
  logic pa_read;
  logic pb_write;
  logic pb_read;
  logic ctrl_write;
  logic parity_gen;
  logic parity_bad;
  logic xcvr_en;
  logic parity_drive;

  // interface bit is active low toward the bus logic
  assign en = ~interface_enable_bit_i;
  assign req = ~bus_req_n_i;
  assign idle = (state_q == sih_pkg::SIH_IDLE);
  assign cs = ~port_chip_select_n_i;
  assign late_wr = t3_second_half_i & cs & ~io_write_n_i;
  assign late_rd = t3_second_half_i & cs & ~io_read_n_i;
  assign pa_write = late_wr & (port_addr_i == sih_pkg::SIH_SEL_PORT_A);
  assign pa_read = late_rd & (port_addr_i == sih_pkg::SIH_SEL_PORT_A);
  assign pb_write = late_wr & (port_addr_i == sih_pkg::SIH_SEL_PORT_B);
  assign pb_read = late_rd & (port_addr_i == sih_pkg::SIH_SEL_PORT_B);
  assign ctrl_write = late_wr & (port_addr_i == sih_pkg::SIH_SEL_CTRL);
  // dma drop needs the whole write, not only its late half
  assign pa_any_write = cs & ~io_write_n_i
                        & (port_addr_i == sih_pkg::SIH_SEL_PORT_A);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // selection never leaves idle: no strobe, no move
      sih_pkg::SIH_IDLE: begin
        if (pa_write && req && bus_oi_i) begin
          state_d = sih_pkg::SIH_WR1;
        end else if (pa_read && !bus_oi_i) begin
          state_d = sih_pkg::SIH_ACKS;
        end else if (pb_write && !data_bit_four_i) begin
          state_d = sih_pkg::SIH_HOLD;
        end else if (pb_write && data_bit_four_i) begin
          state_d = sih_pkg::SIH_CLR0;
        end
      end
      // delay states let data settle before ack
      sih_pkg::SIH_WR1: state_d = sih_pkg::SIH_WR2;
      sih_pkg::SIH_WR2: state_d = sih_pkg::SIH_WR3;
      sih_pkg::SIH_WR3: state_d = sih_pkg::SIH_ACKS;
      sih_pkg::SIH_ACKS: begin
        state_d = bus_oi_i ? sih_pkg::SIH_WR5 : sih_pkg::SIH_IDLE;
      end
      sih_pkg::SIH_WR5: state_d = sih_pkg::SIH_WR6;
      sih_pkg::SIH_WR6: state_d = sih_pkg::SIH_IDLE;
      sih_pkg::SIH_HOLD: begin
        if (pb_read) begin
          state_d = sih_pkg::SIH_LOOP1;
        end
      end
      sih_pkg::SIH_LOOP1: state_d = sih_pkg::SIH_LOOP2;
      sih_pkg::SIH_LOOP2: state_d = sih_pkg::SIH_LOOP3;
      sih_pkg::SIH_LOOP3: state_d = sih_pkg::SIH_IDLE;
      sih_pkg::SIH_CLR0: state_d = sih_pkg::SIH_LOOP2;
      default: state_d = sih_pkg::SIH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= sih_pkg::SIH_IDLE;
    end else if (!en) begin
      state_q <= sih_pkg::SIH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // enable set in 0111, held till req drops or disable
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_drive_enable_q <= 1'b0;
    end else begin
      ack_drive_enable_q <= req & en
        & (ack_drive_enable_q | (state_q == sih_pkg::SIH_ACKS));
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_a_input_flag_q <= 1'b0;
    end else if (ctrl_write) begin
      port_a_input_flag_q <= data_bit_four_i;
    end
  end

  sih_parity u_parity (
    .bus_data_i(bus_data_i),
    .bus_parity_i(bus_parity_i),
    .parity_gen_o(parity_gen),
    .parity_bad_o(parity_bad)
  );

  // set only on input bytes; set wins over hold, clear is state-led
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      parity_error_latch_q <= 1'b0;
    end else if (!en) begin
      parity_error_latch_q <= 1'b0;
    end else if ((state_q == sih_pkg::SIH_ACKS
                  || state_q == sih_pkg::SIH_WR5)
                 && !bus_oi_i && parity_bad) begin
      parity_error_latch_q <= 1'b1;
    end else if (state_q == sih_pkg::SIH_LOOP1
                 || state_q == sih_pkg::SIH_LOOP2) begin
      parity_error_latch_q <= 1'b0;
    end
  end

  assign xcvr_en = port_a_input_flag_q | (bus_oi_i & en);
  // parity drive window; generation leaves latch alone
  assign parity_drive = en & bus_oi_i & xcvr_en & ~port_a_input_flag_q;

  // ack appears once back in idle with the enable held
  assign bus_ack_n_o = ~(ack_drive_enable_q & req & en & idle);
  // dma request only in data phase
  assign dma_request_out_o = idle & ~ack_drive_enable_q & en & req
                             & bus_dc_i & ~pa_any_write;
  assign bus_interrupt_out_o = en & req
    & (~bus_dc_i | (state_q == sih_pkg::SIH_HOLD));
  assign transceiver_enable_n_o = ~xcvr_en;
  assign transceiver_direction_o = bus_oi_i;
  assign parity_out_a_o = parity_gen;
  assign parity_out_b_o = parity_gen;
  assign parity_out_a_oe_o = parity_drive;
  assign parity_out_b_oe_o = parity_drive;
  assign parity_error_latch_o = parity_error_latch_q;
  assign port_a_input_flag_o = port_a_input_flag_q;
  assign state_o = state_q;

  // ---- checks ----
  int unsigned wr_cnt_q;
  logic wr_run_q;

  // counts edges since an accepted output-path write
  always_ff @(posedge clk_i) begin
    if (srst_i || !en) begin
      wr_run_q <= 1'b0;
      wr_cnt_q <= 0;
    end else if (idle && pa_write && req && bus_oi_i) begin
      wr_run_q <= 1'b1;
      wr_cnt_q <= 1;
    end else if (wr_run_q) begin
      wr_cnt_q <= wr_cnt_q + 1;
      if (idle) begin
        wr_run_q <= 1'b0;
      end
    end
  end

  idle_when_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
    interface_enable_bit_i |=> state_q == sih_pkg::SIH_IDLE)
    else $error("state not idle while interface off");

  ack_latency_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (wr_run_q && idle && en) |->
      wr_cnt_q == 32'(sih_pkg::SIH_ACK_DELAY_CLK))
    else $error("output path length wrong");

  // disabling the interface aborts the path back to idle
  write_path_a: assert property (@(posedge clk_i)
    disable iff (srst_i || interface_enable_bit_i)
    (idle && en && pa_write && req && bus_oi_i) |=>
      state_q == sih_pkg::SIH_WR1 ##1 state_q == sih_pkg::SIH_WR2
      ##1 state_q == sih_pkg::SIH_WR3)
    else $error("output path order wrong");

  enable_drop_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!req || !en) |=> !ack_drive_enable_q && bus_ack_n_o)
    else $error("ack enable kept without req");

  enable_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == sih_pkg::SIH_ACKS && req && en) |=> ack_drive_enable_q)
    else $error("ack enable not set in 0111");

  dma_req_a: assert property (@(posedge clk_i) disable iff (srst_i)
    dma_request_out_o |-> idle && req && bus_dc_i && en
      && !ack_drive_enable_q)
    else $error("dma request without cause");

  hold_state_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == sih_pkg::SIH_HOLD && en && !pb_read) |=>
      state_q == sih_pkg::SIH_HOLD)
    else $error("holding state left without read");

  hold_int_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (state_q == sih_pkg::SIH_HOLD && req && en) |-> bus_interrupt_out_o)
    else $error("no interrupt in holding state");

  pa_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ctrl_write |=> port_a_input_flag_q == $past(data_bit_four_i))
    else $error("port A input flag not updated");

  parity_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (idle && en && pb_write && data_bit_four_i) |=> ##2
      !parity_error_latch_q)
    else $error("parity latch not cleared");

  parity_drive_a: assert property (@(posedge clk_i) disable iff (srst_i)
    parity_out_a_oe_o |-> en && bus_oi_i && !port_a_input_flag_q
      && !transceiver_enable_n_o && parity_out_b_oe_o)
    else $error("parity driven outside window");

  write_done_c: cover property (@(posedge clk_i) disable iff (srst_i)
    state_q == sih_pkg::SIH_WR6 ##1 !bus_ack_n_o);
  read_done_c: cover property (@(posedge clk_i) disable iff (srst_i)
    pa_read && idle && !bus_oi_i ##1 state_q == sih_pkg::SIH_ACKS);
  hold_loop_c: cover property (@(posedge clk_i) disable iff (srst_i)
    state_q == sih_pkg::SIH_HOLD ##1 state_q == sih_pkg::SIH_LOOP1);

endmodule

// *** verif/sih_target_model.sv ***
`timescale 1ns/1ps
// far-side target: one byte per request, phase lines held per phase
module sih_target_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic go_i,
  input wire logic dc_i,
  input wire logic oi_i,
  input wire logic [7:0] byte_i,
  input wire logic bad_par_i,
  input wire logic [1:0] lag_i,
  input wire logic ack_n_i,
  output logic req_n_o,
  output logic dc_o,
  output logic oi_o,
  output logic [7:0] data_o,
  output logic parity_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i) begin
    // bus free after reset: no request raised
    if (srst_i) begin
      req_n_o <= 1'h1;
      dc_o <= 1'h0;
      oi_o <= 1'h0;
      data_o <= 8'h00;
      parity_o <= 1'h0;
      cnt_q <= 2'h0;
    end else if (!req_n_o) begin
      if (!ack_n_i && cnt_q == 2'h0)
        req_n_o <= 1'h1;
      else if (!ack_n_i)
        cnt_q <= cnt_q - 2'h1;
    end else if (ack_n_i) begin
      if (go_i) begin
        req_n_o <= 1'h0;
        dc_o <= dc_i;
        oi_o <= oi_i;
        data_o <= byte_i;
        parity_o <= ~^byte_i ^ bad_par_i;
        cnt_q <= lag_i;
      end else begin
        // released bus inverts data and parity every clock, so the last byte comes back every second clock
        data_o <= ~data_o;
        parity_o <= ~parity_o;
      end
    end
  end
endmodule

// *** verif/sih_handshake_tb_top.sv ***
`timescale 1ns/1ps
module sih_handshake_tb_top;
  logic clk_i, srst_i, cs_n, wr_n, rd_n, t3, b4, dis, go, pdc, poi, bad;
  logic [1:0] addr, lag;
  logic [7:0] pbyte, data;
  logic req_n, dc, oi, par, ack_n, dma, intr, txen_n, txdir;
  logic pa, pa_oe, pb, pb_oe, latch, flag;
  logic [3:0] st;
  logic [3:0] exp_q[$];
  int err_count, samples_checked, seed;

  sih_target_model u_tgt (
    .clk_i(clk_i), .srst_i(srst_i), .go_i(go), .dc_i(pdc), .oi_i(poi),
    .byte_i(pbyte), .bad_par_i(bad), .lag_i(lag), .ack_n_i(ack_n),
    .req_n_o(req_n), .dc_o(dc), .oi_o(oi), .data_o(data), .parity_o(par)
  );
  sih_handshake u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .port_chip_select_n_i(cs_n),
    .io_write_n_i(wr_n), .io_read_n_i(rd_n), .port_addr_i(addr),
    .t3_second_half_i(t3), .data_bit_four_i(b4),
    .interface_enable_bit_i(dis), .bus_req_n_i(req_n), .bus_dc_i(dc),
    .bus_oi_i(oi), .bus_data_i(data), .bus_parity_i(par),
    .bus_ack_n_o(ack_n), .dma_request_out_o(dma),
    .bus_interrupt_out_o(intr), .transceiver_enable_n_o(txen_n),
    .transceiver_direction_o(txdir), .parity_out_a_o(pa),
    .parity_out_a_oe_o(pa_oe), .parity_out_b_o(pb),
    .parity_out_b_oe_o(pb_oe), .parity_error_latch_o(latch),
    .port_a_input_flag_o(flag), .state_o(st)
  );

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task comb;
    logic oe;
    oe = !dis & oi & !txen_n & !flag;
    chk(txdir, oi);
    chk(txen_n, !(flag | (oi & !dis)));
    chk({pa_oe, pb_oe}, {oe, oe});
    chk({pa, pb}, {2{~^data}});
  endtask

  task step;
    @(posedge clk_i);
    #1;
    comb;
  endtask

  task cpu(input logic [1:0] a, input logic w, input logic d4);
    {cs_n, t3, addr, b4} = {1'h0, 1'h1, a, d4};
    {wr_n, rd_n} = {!w, w};
    step;
    {cs_n, wr_n, rd_n, t3} = 4'hE;
  endtask

  task start(input logic d, input logic o, input logic b);
    {pdc, poi, bad} = {d, o, b};
    pbyte = 8'($random(seed));
    go = 1'h1;
    step;
    go = 1'h0;
  endtask

  task walk;
    foreach (exp_q[i]) begin
      if (i > 0)
        step;
      chk(st, exp_q[i]);
    end
  endtask

  task xfer_out;
    cpu(sih_pkg::SIH_SEL_PORT_A, 1'h1, 1'h0);
    exp_q = '{4'h9, 4'h1, 4'h3, 4'h7, 4'h6, 4'h2, 4'h0};
    walk;
    chk(ack_n, 1'h0);
    step;
    chk(ack_n, 1'h1);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    $display("watchdog expired");
    conclude;
  end

  initial begin
    seed = 18;
    {cs_n, wr_n, rd_n, t3, b4, go, pdc, poi, bad} = 9'h1C0;
    {addr, lag, pbyte} = 12'h000;
    {dis, srst_i} = 2'h3;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    #1;
    srst_i = 1'h0;
    chk({st, ack_n, flag, latch}, 7'h04);
    cpu(sih_pkg::SIH_SEL_PORT_B, 1'h1, 1'h0);
    chk(st, 4'h0);
    // host enables the interface, state stays idle
    dis = 1'h0;
    step;
    cpu(sih_pkg::SIH_SEL_CTRL, 1'h1, 1'h1);
    chk(flag, 1'h1);
    step;
    // mode word with port A as output
    cpu(sih_pkg::SIH_SEL_CTRL, 1'h1, 1'h0);
    chk(flag, 1'h0);
    $display("test reset and control done");
    for (int k = 0; k < 2; k++) begin
      start(k[0], 1'h1, 1'h0);
      chk({dma, intr}, {k[0], !k[0]});
      xfer_out;
    end
    cpu(sih_pkg::SIH_SEL_PORT_A, 1'h1, 1'h0);
    chk(st, 4'h0);
    $display("test write done");
    lag = 2'h2;
    for (int k = 0; k < 2; k++) begin
      start(k[0], 1'h0, k[0]);
      chk({dma, intr}, {k[0], !k[0]});
      cpu(sih_pkg::SIH_SEL_PORT_A, 1'h0, 1'h0);
      exp_q = '{4'h7, 4'h0};
      walk;
      chk({ack_n, latch}, {1'h0, k[0]});
      repeat (2) step;
      chk(ack_n, 1'h0);
      step;
      chk(ack_n, 1'h1);
    end
    lag = 2'h0;
    cpu(sih_pkg::SIH_SEL_PORT_B, 1'h1, 1'h1);
    exp_q = '{4'h4, 4'hC, 4'h8, 4'h0};
    walk;
    chk(latch, 1'h0);
    $display("test read done");
    cpu(sih_pkg::SIH_SEL_PORT_B, 1'h1, 1'h0);
    repeat (3) step;
    chk(st, 4'hA);
    start(1'h1, 1'h1, 1'h0);
    chk(intr, 1'h1);
    cpu(sih_pkg::SIH_SEL_PORT_B, 1'h0, 1'h0);
    exp_q = '{4'hE, 4'hC, 4'h8, 4'h0};
    walk;
    chk({dma, intr}, 2'h2);
    xfer_out;
    $display("test hold done");
    start(1'h0, 1'h1, 1'h0);
    cpu(sih_pkg::SIH_SEL_PORT_A, 1'h1, 1'h0);
    step;
    dis = 1'h1;
    step;
    chk({st, ack_n}, 5'h01);
    dis = 1'h0;
    step;
    xfer_out;
    $display("test disable done");
    conclude;
  end
endmodule
